// ---- core/bsfl_defines.vh ----
`ifndef BSFL_DEFINES_VH
`define BSFL_DEFINES_VH
// loader states, one-hot
`define BSFL_ST_ADJ        3'b001
`define BSFL_ST_INQ        3'b010
`define BSFL_ST_PGM        3'b100
// bytes on the wire
`define BSFL_SYNC_BYTE     8'h00
`define BSFL_ACK           8'h06
`define BSFL_ERR_SUM       8'h11
`define BSFL_ERR_CMD       8'h80
`define BSFL_ERR_OFFSET    8'h80
// command codes
`define BSFL_CMD_DEVSEL    8'h10
`define BSFL_CMD_CLKSEL    8'h11
`define BSFL_CMD_RATESEL   8'h3F
`define BSFL_CMD_TOPGM     8'h40
`define BSFL_CMD_STATUS    8'h4F
`define BSFL_CMD_PROG      8'h50
`define BSFL_CMD_READ      8'h52
`define BSFL_CMD_SUMCHK    8'h4B
`define BSFL_CMD_BLANKCHK  8'h4D
`define BSFL_INQ_LO        8'h20
`define BSFL_INQ_HI        8'h27
`define BSFL_RSP_OFFSET    8'h10
`define BSFL_RSP_STATUS    8'h5F
`define BSFL_RSP_READ      8'h52
// frame sizes
`define BSFL_PROG_ADDR_LEN 8'd4
`define BSFL_PROG_UNIT     8'd128
`define BSFL_BOOT_SPAN     32'h0000_4000
// no array read path here: read data stand in as erased bytes
`define BSFL_READ_FILL     8'hFF
// bit-rate measurement: zero byte is start plus 8 data bits low
`define BSFL_LOW_BITS      4'd9
`define BSFL_CNT_W         16
`endif

// ---- core/bsfl_loader.v ----
// How it works
// R1: three states; adjustment first after boot-mode reset
// R2: finished rate measurement moves to inquiry/selection
// R3: host sends zero byte; low period timing gives bit period
// R4: new-bit-rate command re-arms bit-rate measurement
// R5: transition command erases both arrays, then enters programming state
// R6: programming state starts sum and blank checks on command
// R7: inquiries and acknowledge are single standalone bytes
// R8: selection frames: code, size of data, data, checksum
// R9: all frame bytes including checksum sum to zero modulo 256
// R10: errors are reported as error code byte then error type byte
// R11: host program frame: code, 4-byte address, 128 data, checksum
// R12: read reply: code, 4-byte size, data, checksum
// R13: boot array at zero blocks program/erase; reads beyond span undefined; code blocks program only, erase still runs
// R14: software waits four no-ops after array select write
// R15: software masks interrupts while switching arrays
// R16: vector table follows array unless ram vector enable set
// R17: parallel programmer supplies 6 MHz clock and polls status
// R18: host sends device, clock, rate selections in order; last wins
// R19: accepted selection acked with 0x06; bad checksum gives error 0x11
// R20: command invalid in current state gets an error reply; code ignores all bytes while bit-rate measurement is armed
`timescale 1ns/1ps
`include "bsfl_defines.vh"
module bsfl_loader #(
  parameter CW = `BSFL_CNT_W
) (
  // clock and reset
  input  wire          clk,
  input  wire          rstn,
  // received bytes from serial_comm_unit
  input  wire          rxdPin,
  input  wire [7:0]    rxByte,
  input  wire          rxValid,
  // bytes to serial_comm_unit
  output wire [7:0]    txByte,
  output wire          txValid,
  input  wire          txReady,
  // array switching
  input  wire          bootArraySel,
  input  wire          ramVectorEnable,
  // flash engine handshake
  output reg           eraseReq_r,
  output reg           sumChkReq_r,
  output reg           blankChkReq_r,
  output reg           progReq_r,
  input  wire          flashDone,
  // status
  output reg  [2:0]    loaderState_r,
  output reg  [CW-1:0] bitPeriod_r,
  output reg           vectorInRam_r,
  output reg           vectorBootArray_r,
  output reg           progBlocked_r
);
  localparam P_IDLE = 7'b0000001;
  localparam P_SIZE = 7'b0000010;
  localparam P_DATA = 7'b0000100;
  localparam P_SUM  = 7'b0001000;
  localparam P_WAIT = 7'b0010000;
  localparam P_SEND = 7'b0100000;
  localparam P_RD   = 7'b1000000;

  reg  [1:0] rxSync_r;
  reg  [6:0] ps_r;
  reg  [7:0] cmd_r;
  reg  [7:0] left_r;
  reg  [7:0] sum_r;
  reg  [7:0] q0_r;
  reg  [7:0] q1_r;
  reg  [1:0] qn_r;
  reg        armAdj_r;
  reg        afterOk_r;
  reg        rspTaken_r;
  wire [CW-1:0] measured;
  wire       measDone;
  wire       bufReady;
  reg  [8:0] rdIdx_r;
  reg  [7:0] rdSum_r;
  reg  [7:0] rdLen_r;
  reg  [7:0] lastData_r;
  wire [8:0] rdNext = rdIdx_r + 9'h001;
  wire [8:0] rdLast = {1'b0, rdLen_r} + 9'h005;
  // offer q0 once per byte; the taken flag blocks a second push of it
  wire       qPush = ((ps_r == P_SEND && qn_r != 2'd0) ||
                      ps_r == P_RD) && !rspTaken_r;
  wire [7:0] sumNxt = sum_r + rxByte;

  // two-flop synchroniser on the raw receive pin
  always @(posedge clk) begin
    if (!rstn)
      rxSync_r <= 2'b11;
    else
      rxSync_r <= {rxSync_r[0], rxdPin};
  end

  bsfl_low_timer #(.CW(CW)) uTimer (
    .clk         (clk),
    .rstn        (rstn),
    .arm         (armAdj_r),
    .rxd         (rxSync_r[1]),
    .bitCycles_r (measured),
    .done_r      (measDone)
  );

  bsfl_skid_buf #(.W(8)) uTxBuf (
    .clk        (clk),
    .rstn       (rstn),
    .inData     (q0_r),
    .inValid    (qPush),
    .inReady_r  (bufReady),
    .outData_r  (txByte),
    .outValid_r (txValid),
    .outReady   (txReady)
  );

  // vector table placement and protection follow the array selection
  always @(posedge clk) begin
    if (!rstn) begin
      vectorInRam_r     <= 1'b0;
      vectorBootArray_r <= 1'b0;
      progBlocked_r     <= 1'b0;
    end else begin
      vectorInRam_r     <= ramVectorEnable; // R16
      vectorBootArray_r <= bootArraySel && !ramVectorEnable; // R16
      progBlocked_r     <= bootArraySel; // R13
    end
  end

  // command parser and loader state machine
  always @(posedge clk) begin
    if (!rstn) begin
      loaderState_r <= `BSFL_ST_ADJ; // R1
      bitPeriod_r   <= {CW{1'b0}};
      armAdj_r      <= 1'b1;
      ps_r          <= P_IDLE;
      cmd_r         <= 8'h00;
      left_r        <= 8'h00;
      sum_r         <= 8'h00;
      q0_r          <= 8'h00;
      q1_r          <= 8'h00;
      qn_r          <= 2'd0;
      afterOk_r     <= 1'b0;
      rspTaken_r    <= 1'b0;
      rdIdx_r       <= 9'h000;
      rdSum_r       <= 8'h00;
      rdLen_r       <= 8'h00;
      lastData_r    <= 8'h00;
      eraseReq_r    <= 1'b0;
      sumChkReq_r   <= 1'b0;
      blankChkReq_r <= 1'b0;
      progReq_r     <= 1'b0;
    end else begin
      rspTaken_r <= 1'b0;
      if (measDone) begin
        bitPeriod_r   <= measured; // R3
        armAdj_r      <= 1'b0;
        loaderState_r <= `BSFL_ST_INQ; // R2
      end
      case (ps_r)
        P_IDLE: begin
          if (rxValid && !armAdj_r) begin
            cmd_r <= rxByte;
            sum_r <= rxByte;
            if (loaderState_r == `BSFL_ST_INQ &&
                rxByte >= `BSFL_INQ_LO && rxByte <= `BSFL_INQ_HI) begin
              q0_r <= rxByte + `BSFL_RSP_OFFSET; // R7
              q1_r <= 8'h00;
              qn_r <= 2'd1;
              ps_r <= P_SEND;
            end else if (loaderState_r == `BSFL_ST_INQ &&
                         (rxByte == `BSFL_CMD_DEVSEL ||
                          rxByte == `BSFL_CMD_CLKSEL ||
                          rxByte == `BSFL_CMD_RATESEL)) begin
              ps_r <= P_SIZE; // R8
            end else if (loaderState_r == `BSFL_ST_PGM &&
                         rxByte == `BSFL_CMD_READ) begin
              ps_r <= P_SIZE; // R12
            end else if (loaderState_r == `BSFL_ST_INQ &&
                         rxByte == `BSFL_CMD_TOPGM) begin
              eraseReq_r <= 1'b1; // R5
              ps_r       <= P_WAIT;
            end else if (loaderState_r == `BSFL_ST_PGM &&
                         rxByte == `BSFL_CMD_STATUS) begin
              q0_r <= `BSFL_RSP_STATUS;
              qn_r <= 2'd1;
              ps_r <= P_SEND;
            end else if (loaderState_r == `BSFL_ST_PGM &&
                         rxByte == `BSFL_CMD_SUMCHK) begin
              sumChkReq_r <= 1'b1; // R6
              ps_r        <= P_WAIT;
            end else if (loaderState_r == `BSFL_ST_PGM &&
                         rxByte == `BSFL_CMD_BLANKCHK) begin
              blankChkReq_r <= 1'b1; // R6
              ps_r          <= P_WAIT;
            end else if (loaderState_r == `BSFL_ST_PGM &&
                         rxByte == `BSFL_CMD_PROG) begin
              left_r <= `BSFL_PROG_ADDR_LEN + `BSFL_PROG_UNIT; // R11
              ps_r   <= P_DATA;
            end else begin
              q0_r <= rxByte + `BSFL_ERR_OFFSET; // R20
              q1_r <= `BSFL_ERR_CMD; // R10
              qn_r <= 2'd2;
              ps_r <= P_SEND;
            end
          end
        end
        P_SIZE: begin
          if (rxValid) begin
            sum_r  <= sumNxt; // R9
            left_r <= rxByte;
            ps_r   <= (rxByte == 8'h00) ? P_SUM : P_DATA;
          end
        end
        P_DATA: begin
          if (rxValid) begin
            sum_r  <= sumNxt; // R9
            left_r <= left_r - 8'd1;
            lastData_r <= rxByte;
            if (left_r == 8'd1)
              ps_r <= P_SUM;
          end
        end
        P_SUM: begin
          if (rxValid) begin
            if (sumNxt == 8'h00) begin // R9
              if (cmd_r == `BSFL_CMD_PROG) begin
                progReq_r <= !progBlocked_r; // R13
                ps_r      <= P_WAIT;
              end else if (cmd_r == `BSFL_CMD_READ) begin
                // last data byte of the request is the read length
                q0_r    <= `BSFL_RSP_READ; // R12
                rdLen_r <= lastData_r;
                rdIdx_r <= 9'h000;
                rdSum_r <= 8'h00;
                ps_r    <= P_RD;
              end else begin
                q0_r <= `BSFL_ACK; // R19
                qn_r <= 2'd1;
                ps_r <= P_SEND;
                if (cmd_r == `BSFL_CMD_RATESEL)
                  afterOk_r <= 1'b1; // R4
              end
            end else begin
              q0_r <= cmd_r + `BSFL_ERR_OFFSET; // R10
              q1_r <= `BSFL_ERR_SUM; // R19
              qn_r <= 2'd2;
              ps_r <= P_SEND;
            end
          end
        end
        P_WAIT: begin
          eraseReq_r    <= 1'b0;
          sumChkReq_r   <= 1'b0;
          blankChkReq_r <= 1'b0;
          progReq_r     <= 1'b0;
          if (flashDone || (cmd_r == `BSFL_CMD_PROG && progBlocked_r)) begin
            q0_r <= `BSFL_ACK;
            qn_r <= 2'd1;
            ps_r <= P_SEND;
            if (cmd_r == `BSFL_CMD_TOPGM)
              loaderState_r <= `BSFL_ST_PGM; // R5
            if (cmd_r == `BSFL_CMD_PROG && progBlocked_r) begin
              q0_r <= cmd_r + `BSFL_ERR_OFFSET; // R13
              q1_r <= `BSFL_ERR_CMD;
              qn_r <= 2'd2;
            end
          end
        end
        P_SEND: begin
          if (bufReady && !rspTaken_r) begin
            rspTaken_r <= 1'b1;
            q0_r       <= q1_r;
            qn_r       <= qn_r - 2'd1;
            if (qn_r == 2'd1) begin
              ps_r <= P_IDLE;
              if (afterOk_r) begin
                afterOk_r <= 1'b0;
                armAdj_r  <= 1'b1; // R4
              end
            end
          end
        end
        // read reply: code, 4-byte size, data, then the zero-sum byte
        P_RD: begin
          if (bufReady && !rspTaken_r) begin
            rspTaken_r <= 1'b1;
            rdSum_r    <= rdSum_r + q0_r; // R9
            rdIdx_r    <= rdNext;
            if (rdIdx_r == rdLast)
              ps_r <= P_IDLE;
            else if (rdNext < 9'h004)
              q0_r <= 8'h00; // R12
            else if (rdNext == 9'h004)
              q0_r <= rdLen_r; // R12
            else if (rdNext < rdLast)
              q0_r <= `BSFL_READ_FILL;
            else
              q0_r <= 8'h00 - (rdSum_r + q0_r); // R9
          end
        end
        default: ps_r <= P_IDLE;
      endcase
    end
  end
endmodule // bsfl_loader

// ---- core/bsfl_low_timer.v ----
`timescale 1ns/1ps
`include "bsfl_defines.vh"
module bsfl_low_timer #(
  parameter CW = `BSFL_CNT_W
) (
  // clock and reset
  input  wire          clk,
  input  wire          rstn,
  // control and synchronised line
  input  wire          arm,
  input  wire          rxd,
  // result
  output reg  [CW-1:0] bitCycles_r,
  output reg           done_r
);
  reg [CW-1:0] lowCnt_r;
  reg          busy_r;
  reg          prev_r;

  // time the low run of the zero byte and divide by nine bits
  always @(posedge clk) begin
    if (!rstn) begin
      lowCnt_r    <= {CW{1'b0}};
      busy_r      <= 1'b0;
      prev_r      <= 1'b1;
      bitCycles_r <= {CW{1'b0}};
      done_r      <= 1'b0;
    end else begin
      prev_r <= rxd;
      done_r <= 1'b0;
      if (arm && !busy_r && prev_r && !rxd) begin
        busy_r   <= 1'b1;
        lowCnt_r <= {{(CW-1){1'b0}}, 1'b1};
      end else if (busy_r && !rxd) begin
        if (lowCnt_r != {CW{1'b1}})
          lowCnt_r <= lowCnt_r + 1'b1;
      end else if (busy_r) begin
        busy_r      <= 1'b0;
        bitCycles_r <= lowCnt_r / `BSFL_LOW_BITS; // R3
        done_r      <= 1'b1;
      end
    end
  end
endmodule // bsfl_low_timer

// ---- core/bsfl_skid_buf.v ----
`timescale 1ns/1ps
module bsfl_skid_buf #(
  parameter W = 8
) (
  // clock and reset
  input  wire         clk,
  input  wire         rstn,
  // fill side
  input  wire [W-1:0] inData,
  input  wire         inValid,
  output reg          inReady_r,
  // drain side
  output reg  [W-1:0] outData_r,
  output reg          outValid_r,
  input  wire         outReady
);
  reg [W-1:0] spare_r;
  reg         spareV_r;
  wire        push = inValid && inReady_r;
  wire        pop  = outValid_r && outReady;

  // two-entry buffer: output slot plus one spare
  always @(posedge clk) begin
    if (!rstn) begin
      outData_r  <= {W{1'b0}};
      outValid_r <= 1'b0;
      spare_r    <= {W{1'b0}};
      spareV_r   <= 1'b0;
      inReady_r  <= 1'b1;
    end else begin
      if (pop || !outValid_r) begin
        if (spareV_r) begin
          outData_r  <= spare_r;
          outValid_r <= 1'b1;
          spareV_r   <= push;
          spare_r    <= inData;
          inReady_r  <= 1'b1;
        end else begin
          outData_r  <= inData;
          outValid_r <= push;
        end
      end else if (push) begin
        spare_r   <= inData;
        spareV_r  <= 1'b1;
        inReady_r <= 1'b0;
      end
    end
  end
endmodule // bsfl_skid_buf

// ---- verification/bsfl_host_model.sv ----
`timescale 1ns/1ps
module bsfl_host_model (
  // clock
  input wire       clk,
  // toward the loader
  output reg       rxdPin,
  output reg [7:0] rxByte,
  output reg       rxValid,
  output reg       txReady
);
  // line idles high, nothing offered
  initial begin
    rxdPin = 1'b1;
    rxByte = 8'h00;
    rxValid = 1'b0;
    txReady = 1'b0;
  end
  // host stalls its receiver about one cycle in three
  always @(posedge clk) txReady <= #1 ($urandom % 3) != 0;
  // zero byte: start bit and eight data bits low
  task sendZero(input integer t);
    begin
      @(posedge clk) #1 rxdPin = 1'b0;
      repeat (9 * t) @(posedge clk);
      #1 rxdPin = 1'b1;
    end
  endtask
  // one byte as a single-cycle pulse, then spaced like a serial line
  task sendByte(input [7:0] b);
    begin
      @(posedge clk) #1 rxByte = b;
      rxValid = 1'b1;
      @(posedge clk) #1 rxValid = 1'b0;
      rxByte = ~b;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule // bsfl_host_model

// ---- verification/bsfl_loader_assertions.sv ----
`timescale 1ns/1ps
`include "bsfl_defines.vh"
module bsfl_loader_assertions (
  // clock and reset
  input wire       clk,
  input wire       rstn,
  // byte out
  input wire [7:0] txByte,
  input wire       txValid,
  input wire       txReady,
  // array switching
  input wire       bootArraySel,
  input wire       ramVectorEnable,
  // flash requests and status
  input wire       eraseReq_r,
  input wire       sumChkReq_r,
  input wire       blankChkReq_r,
  input wire       progReq_r,
  input wire [2:0] loaderState_r,
  input wire       vectorInRam_r,
  input wire       vectorBootArray_r,
  input wire       progBlocked_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // state moves and what each state may do
  a_state_onehot: assert property ($onehot(loaderState_r))
    else $error("state not one-hot");
  a_adjust_exit: assert property (loaderState_r == `BSFL_ST_ADJ |=>
    loaderState_r != `BSFL_ST_PGM) else $error("adjust skipped inquiry");
  a_adjust_silent: assert property (loaderState_r == `BSFL_ST_ADJ |->
    !txValid) else $error("byte sent while adjusting");
  a_pgm_stays: assert property (loaderState_r == `BSFL_ST_PGM |=>
    loaderState_r == `BSFL_ST_PGM) else $error("left program state");
  a_erase_inq: assert property (eraseReq_r |->
    loaderState_r == `BSFL_ST_INQ) else $error("erase outside inquiry");
  a_check_pgm: assert property (sumChkReq_r || blankChkReq_r ||
    progReq_r |-> loaderState_r == `BSFL_ST_PGM) else $error("check early");
  // output byte held until taken, program refused on boot array
  a_tx_hold: assert property (txValid && !txReady |=>
    txValid && $stable(txByte)) else $error("tx byte dropped");
  a_prog_block: assert property (progReq_r |-> !progBlocked_r)
    else $error("program while blocked");
  a_vector_follow: assert property ($past(rstn) &&
    !$past(ramVectorEnable) |-> vectorBootArray_r == $past(bootArraySel))
    else $error("vector table not following array");
  a_vector_ram: assert property ($past(rstn) |->
    vectorInRam_r == $past(ramVectorEnable)) else $error("ram vector lost");
  a_block_follow: assert property ($past(rstn) |->
    progBlocked_r == $past(bootArraySel)) else $error("block not following");
endmodule // bsfl_loader_assertions
bind bsfl_loader bsfl_loader_assertions chk (.clk(clk), .rstn(rstn),
  .txByte(txByte), .txValid(txValid), .txReady(txReady),
  .bootArraySel(bootArraySel), .ramVectorEnable(ramVectorEnable),
  .eraseReq_r(eraseReq_r), .sumChkReq_r(sumChkReq_r),
  .blankChkReq_r(blankChkReq_r), .progReq_r(progReq_r),
  .loaderState_r(loaderState_r), .vectorInRam_r(vectorInRam_r),
  .vectorBootArray_r(vectorBootArray_r),
  .progBlocked_r(progBlocked_r));

// ---- verification/test_boot_serial_flash_loader.sv ----
`timescale 1ns/1ps
`include "bsfl_defines.vh"
module test_boot_serial_flash_loader;
  reg         clk, rstn, bootArraySel, ramVectorEnable, flashDone;
  wire        rxdPin, rxValid, txValid, txReady, vecRam;
  wire [7:0]  rxByte, txByte;
  wire        eraseReq_r, sumChkReq_r, blankChkReq_r, progReq_r;
  wire        vectorBootArray_r, progBlocked_r;
  wire [2:0]  loaderState_r;
  wire [15:0] bitPeriod_r;
  integer     failures, checks_done, i, n;
  reg  [7:0]  txQ[$], reqQ[$], fr[0:140], sum;
  bsfl_host_model host (.clk(clk), .rxdPin(rxdPin), .rxByte(rxByte),
    .rxValid(rxValid), .txReady(txReady));
  bsfl_loader uut (.clk(clk), .rstn(rstn), .rxdPin(rxdPin), .rxByte(rxByte),
    .rxValid(rxValid), .txByte(txByte), .txValid(txValid), .txReady(txReady),
    .bootArraySel(bootArraySel), .ramVectorEnable(ramVectorEnable),
    .eraseReq_r(eraseReq_r), .sumChkReq_r(sumChkReq_r),
    .blankChkReq_r(blankChkReq_r), .progReq_r(progReq_r),
    .flashDone(flashDone), .loaderState_r(loaderState_r),
    .bitPeriod_r(bitPeriod_r), .vectorInRam_r(vecRam),
    .vectorBootArray_r(vectorBootArray_r), .progBlocked_r(progBlocked_r));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task cmpVal(input [47:0] what, input [15:0] exp, input [15:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("mismatch %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task cmpTx(input [7:0] exp, input [7:0] got);
    cmpVal("tx", exp, got);
  endtask
  task cmpReq(input [7:0] exp, input [7:0] got);
    cmpVal("req", exp, got);
  endtask
  // take the oldest note whenever a byte or a flash request shows
  always @(posedge clk) begin
    if (txValid === 1'b1 && txReady === 1'b1)
      cmpTx(txQ.size() ? txQ.pop_front() : 8'hxx, txByte);
    if (|{eraseReq_r, sumChkReq_r, blankChkReq_r, progReq_r})
      cmpReq(reqQ.size() ? reqQ.pop_front() : 8'hxx,
        {eraseReq_r, sumChkReq_r, blankChkReq_r, progReq_r});
  end
  // flash engine ends each request three cycles later
  initial begin
    flashDone = 1'b0;
    forever begin
      @(posedge clk);
      if (eraseReq_r | sumChkReq_r | blankChkReq_r | progReq_r) begin
        repeat (3) @(posedge clk);
        #1 flashDone = 1'b1;
        @(posedge clk) #1 flashDone = 1'b0;
      end
    end
  end
  task close_out;
    begin
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // wait for state s and every noted result, bounded
  task waitFor(input [2:0] s);
    begin
      i = 0;
      while ((loaderState_r !== s || txQ.size() || reqQ.size()) && i < 3000)
      begin
        @(posedge clk);
        i = i + 1;
      end
      if (i >= 3000) begin
        failures = failures + 1;
        close_out;
      end
      repeat (8) @(posedge clk);
      #1;
    end
  endtask
  // send fr[0..n-1] and a zero-sum byte, spoiled by xor with sp
  task sendFrame(input [7:0] sp);
    integer k;
    begin
      sum = 8'h00;
      for (k = 0; k < n; k = k + 1) begin
        host.sendByte(fr[k]);
        sum = sum - fr[k];
      end
      host.sendByte(sum ^ sp);
    end
  endtask
  task selFrame(input [7:0] c, input [7:0] len, input [7:0] sp);
    integer k;
    begin
      fr[0] = c;
      fr[1] = len;
      for (k = 0; k < len; k = k + 1)
        fr[k + 2] = 8'($urandom);
      n = len + 2;
      if (sp == 8'h00)
        txQ.push_back(`BSFL_ACK);
      else begin
        txQ.push_back(c + `BSFL_ERR_OFFSET);
        txQ.push_back(`BSFL_ERR_SUM);
      end
      sendFrame(sp);
      waitFor(`BSFL_ST_INQ);
    end
  endtask
  task pgmCmd(input [7:0] c, input [7:0] rq, input [7:0] rsp);
    begin
      if (rq != 8'h00)
        reqQ.push_back(rq);
      txQ.push_back(rsp);
      host.sendByte(c);
      waitFor(`BSFL_ST_PGM);
    end
  endtask
  // program frame: code, address, 128 data, sum; refused on boot array
  task progFrame(input blk);
    integer k;
    begin
      // select changes only while no command or request is in flight
      bootArraySel = blk;
      ramVectorEnable = 1'($urandom);
      // four quiet cycles after the array select write, then look
      repeat (4) @(posedge clk);
      #1 cmpVal("vector", {ramVectorEnable, blk & ~ramVectorEnable, blk},
        {vecRam, vectorBootArray_r, progBlocked_r});
      fr[0] = `BSFL_CMD_PROG;
      for (k = 1; k < 133; k = k + 1)
        fr[k] = 8'($urandom);
      n = 133;
      if (blk) begin
        txQ.push_back(`BSFL_CMD_PROG + `BSFL_ERR_OFFSET);
        txQ.push_back(`BSFL_ERR_CMD);
      end else begin
        reqQ.push_back(8'h01);
        txQ.push_back(`BSFL_ACK);
      end
      sendFrame(8'h00);
      waitFor(`BSFL_ST_PGM);
    end
  endtask
  // main sequence
  initial begin
    failures = 0;
    checks_done = 0;
    rstn = 1'b0;
    bootArraySel = 1'b0;
    ramVectorEnable = 1'b0;
    i = $urandom(94);
    repeat (20) @(posedge clk);
    #1 cmpVal("state", `BSFL_ST_ADJ, loaderState_r);
    rstn = 1'b1;
    // an inquiry before the zero byte must go unanswered
    host.sendByte(`BSFL_INQ_LO);
    host.sendZero(8);
    waitFor(`BSFL_ST_INQ);
    cmpVal("period", 16'h0008, bitPeriod_r);
    for (n = `BSFL_INQ_LO; n <= `BSFL_INQ_HI; n = n + 1) begin
      txQ.push_back(n[7:0] + `BSFL_RSP_OFFSET);
      host.sendByte(n[7:0]);
      waitFor(`BSFL_ST_INQ);
    end
    selFrame(`BSFL_CMD_DEVSEL, 8'h04, 8'h00);
    selFrame(`BSFL_CMD_DEVSEL, 8'h04, 8'h01);
    selFrame(`BSFL_CMD_CLKSEL, 8'h01, 8'h80);
    selFrame(`BSFL_CMD_CLKSEL, 8'h01, 8'h00);
    selFrame(`BSFL_CMD_RATESEL, 8'h02, 8'h00);
    host.sendZero(5);
    waitFor(`BSFL_ST_INQ);
    cmpVal("period", 16'h0005, bitPeriod_r);
    txQ.push_back(`BSFL_CMD_STATUS + `BSFL_ERR_OFFSET);
    txQ.push_back(`BSFL_ERR_CMD);
    host.sendByte(`BSFL_CMD_STATUS);
    waitFor(`BSFL_ST_INQ);
    pgmCmd(`BSFL_CMD_TOPGM, 8'h08, `BSFL_ACK);
    pgmCmd(`BSFL_CMD_STATUS, 8'h00, `BSFL_RSP_STATUS);
    pgmCmd(`BSFL_CMD_SUMCHK, 8'h04, `BSFL_ACK);
    pgmCmd(`BSFL_CMD_BLANKCHK, 8'h02, `BSFL_ACK);
    progFrame(1'b0);
    progFrame(1'b1);
    progFrame(1'b0);
    // memory read: code, size, address, length; reply with 4-byte size
    fr[0] = `BSFL_CMD_READ;
    fr[1] = 8'h05;
    for (i = 2; i < 6; i = i + 1)
      fr[i] = 8'($urandom);
    fr[6] = 8'($urandom % 9);
    sum = `BSFL_RSP_READ + fr[6];
    txQ.push_back(`BSFL_RSP_READ);
    for (i = 0; i < 3; i = i + 1)
      txQ.push_back(8'h00);
    txQ.push_back(fr[6]);
    for (i = 0; i < fr[6]; i = i + 1) begin
      txQ.push_back(`BSFL_READ_FILL);
      sum = sum + `BSFL_READ_FILL;
    end
    txQ.push_back(8'h00 - sum);
    n = 7;
    sendFrame(8'h00);
    waitFor(`BSFL_ST_PGM);
    close_out;
  end
endmodule // test_boot_serial_flash_loader
